// [inc/rsp_pkg.sv]
package rsp_pkg;
   // Clock
   localparam int CLK_PERIOD_NS = 40;

   // Register byte offsets
   localparam logic [3:0] MCU_CONTROL_OFS     = 4'h0;
   localparam logic [3:0] POWER_REDUCTION_OFS = 4'h4;
   localparam logic [3:0] SYS_STATUS_OFS      = 4'h8;

   // Control register fields
   localparam int SLEEP_ENABLE_BIT = 5;
   localparam int SLEEP_SEL_HI     = 4;
   localparam int SLEEP_SEL_LO     = 3;
   localparam int MCU_RSVD_BIT     = 2;
   localparam logic [7:0] MCU_CONTROL_RST = 8'h00;
   localparam logic [7:0] MCU_RSVD_MASK   = 8'h04;

   // Power-reduction fields
   localparam int GATE_TIMER16   = 3;
   localparam int GATE_TIMER8    = 2;
   localparam int GATE_SERIAL_IF = 1;
   localparam int GATE_ADC       = 0;
   localparam logic [7:0] POWER_REDUCTION_RST = 8'h00;
   localparam logic [7:0] PRR_RSVD_MASK       = 8'hf0;

   // Sleep-mode select codes
   localparam logic [1:0] SM_IDLE  = 2'h0;
   localparam logic [1:0] SM_ADCNR = 2'h1;
   localparam logic [1:0] SM_PDOWN = 2'h2;
   localparam logic [1:0] SM_STDBY = 2'h3;

   typedef enum logic [5:0] {
      RSP_ACTIVE = 6'h01,
      RSP_IDLE   = 6'h02,
      RSP_ADCNR  = 6'h04,
      RSP_PDOWN  = 6'h08,
      RSP_STDBY  = 6'h10,
      RSP_WAKE   = 6'h20
   } rsp_state_t;

   // Fuse codes
   localparam logic [2:0] BOD_FUSE_OFF = 3'h7;
   localparam logic [3:0] CLOCK_SELECT_FUSES_EXTCLK = 4'h0;

   // Times and cycle counts (least times, rounded up)
   localparam int STBY_WAKE_CYC  = 6;
   localparam int BOD_MIN_NS     = 2000;
   localparam int BOD_MIN_CYC    = (BOD_MIN_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
   localparam int TOUT_SHORT_NS  = 240;
   localparam int TOUT_SHORT_CYC = (TOUT_SHORT_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
   localparam int TOUT_MID_US    = 4000;
   localparam int TOUT_MID_CYC   = (TOUT_MID_US * 1000 + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
   localparam int TOUT_LONG_US   = 64000;
   localparam int TOUT_LONG_CYC  = (TOUT_LONG_US * 1000 + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
   localparam int TOUT_W         = 21;
endpackage : rsp_pkg

// [verilog/rsp_sync.sv]
`timescale 1ns/1ps
module rsp_sync #(
   parameter int         W       = 1,
   parameter logic [0:0] RST_VAL = 1'b0
) (
   input  wire logic         clk_in,
   input  wire logic         arst_n_in,
   input  wire logic [W-1:0] data_in,
   output logic      [W-1:0] data_out
);
   logic [W-1:0] stage1_ff;
   logic [W-1:0] stage2_ff;

   // Two-flop synchroniser, first stage feeds only the second
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         stage1_ff <= {W{RST_VAL}};
         stage2_ff <= {W{RST_VAL}};
      end else begin
         stage1_ff <= data_in;
         stage2_ff <= stage1_ff;
      end
   end

   assign data_out = stage2_ff;
endmodule : rsp_sync

// [verilog/rsp_delay_cnt.sv]
`timescale 1ns/1ps
module rsp_delay_cnt #(
   parameter int W = 21
) (
   input  wire logic         clk_in,
   input  wire logic         arst_n_in,
   input  wire logic         hold_in,
   input  wire logic [W-1:0] load_val_in,
   output logic              done_out
);
   logic [W-1:0] cnt_ff;
   logic         done_ff;
   logic [W-1:0] nxt_cnt;
   logic         nxt_done;

   // Restart while any source holds, finish after load_val cycles
   assign nxt_cnt  = hold_in ? '0 :
                     (done_ff ? cnt_ff : cnt_ff + W'(1));
   assign nxt_done = !hold_in && (done_ff || (cnt_ff + W'(1) >= load_val_in));

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cnt_ff  <= '0;
         done_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         done_ff <= nxt_done;
      end
   end

   assign done_out = done_ff;
endmodule : rsp_delay_cnt

// [verilog/rsp_top.sv]
`timescale 1ns/1ps
module rsp_top
   import rsp_pkg::*;
#(
   parameter int TOUT_MID  = rsp_pkg::TOUT_MID_CYC,
   parameter int TOUT_LONG = rsp_pkg::TOUT_LONG_CYC
) (
   input  wire logic        clk_in,
   input  wire logic        resetn_in,
   input  wire logic [3:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   output logic      [31:0] avs_readdata_out,
   output logic             avs_waitrequest_out,
   input  wire logic        poweron_low_in,
   input  wire logic        reset_pin_n_in,
   input  wire logic        reset_pin_enable_in,
   input  wire logic        wdog_expire_in,
   input  wire logic        wdog_enable_in,
   input  wire logic        brownout_low_in,
   input  wire logic [2:0]  brownout_level_fuses_in,
   input  wire logic [1:0]  startup_time_fuses_in,
   input  wire logic [3:0]  clock_select_fuses_in,
   input  wire logic        comparator_bandgap_select_in,
   input  wire logic        adc_enable_in,
   input  wire logic        sleep_instr_in,
   input  wire logic        wake_event_in,
   output logic             sys_reset_out,
   output logic             reset_vector_start_out,
   output logic             clk_cpu_en_out,
   output logic             clk_io_en_out,
   output logic             clk_adc_en_out,
   output logic             osc_en_out,
   output logic [3:0]       periph_clk_en_out,
   output logic [3:0]       periph_access_en_out,
   output logic             adc_shutdown_out,
   output logic             acmp_mux_en_out,
   output logic             bandgap_en_out
);
   import rsp_pkg::*;

   logic [7:0]        mcu_control_ff;
   logic [7:0]        power_reduction_ff;
   rsp_state_t        state_ff;
   rsp_state_t        nxt_state;
   logic [2:0]        wake_cnt_ff;
   logic              wait_ff;
   logic [31:0]       rdata_ff;
   logic              int_rst_ff;
   logic              start_ff;
   logic              wd_prev_ff;
   logic              wd_pulse_ff;
   logic [7:0]        bod_cnt_ff;
   logic              bod_rst_ff;
   logic              bandgap_ff;
   logic              cpu_en_ff;
   logic              io_en_ff;
   logic              adc_en_ff;
   logic              osc_ff;
   logic [3:0]        pclk_ff;
   logic [3:0]        pacc_ff;
   logic              adc_off_ff;
   logic              mux_ok_ff;

   function automatic logic [TOUT_W-1:0] tout_sel(input logic [1:0] startup_time_fuses,
                                                  input logic [3:0] clock_select_fuses);
      tout_sel = TOUT_W'(TOUT_LONG);
      if (clock_select_fuses == CLOCK_SELECT_FUSES_EXTCLK || startup_time_fuses == 2'h0) begin
         tout_sel = TOUT_W'(TOUT_SHORT_CYC);
      end else if (startup_time_fuses == 2'h1) begin
         tout_sel = TOUT_W'(TOUT_MID);
      end
   endfunction : tout_sel

   // Clockless reset sources
   wire raw_rst_n = resetn_in && !poweron_low_in &&
                    !(reset_pin_enable_in && !reset_pin_n_in);

   wire rel_s;
   wire bod_low_s;
   wire wd_s;
   wire cnt_done;
   rsp_sync #(.W(1), .RST_VAL(1'b0)) u_rel_sync (
      .clk_in   (clk_in),
      .arst_n_in(raw_rst_n),
      .data_in  (1'b1),
      .data_out (rel_s)
   );
   rsp_sync #(.W(2), .RST_VAL(1'b0)) u_in_sync (
      .clk_in   (clk_in),
      .arst_n_in(resetn_in),
      .data_in  ({brownout_low_in, wdog_expire_in}),
      .data_out ({bod_low_s, wd_s})
   );

   wire bod_enabled = (brownout_level_fuses_in != BOD_FUSE_OFF);
   wire bod_hit     = bod_enabled && bod_low_s &&
                      (bod_cnt_ff >= 8'(BOD_MIN_CYC - 1));
   wire src_hold    = !rel_s || bod_rst_ff || wd_pulse_ff;

   rsp_delay_cnt #(.W(TOUT_W)) u_delay (
      .clk_in     (clk_in),
      .arst_n_in  (raw_rst_n),
      .hold_in    (src_hold),
      .load_val_in(tout_sel(startup_time_fuses_in, clock_select_fuses_in)),
      .done_out   (cnt_done)
   );

   // Brown-out filter and watchdog pulse
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         bod_cnt_ff  <= 8'h00;
         bod_rst_ff  <= 1'b0;
         wd_prev_ff  <= 1'b0;
         wd_pulse_ff <= 1'b0;
      end else begin
         bod_cnt_ff  <= (bod_enabled && bod_low_s && !bod_hit) ?
                        bod_cnt_ff + 8'h01 :
                        (bod_low_s ? bod_cnt_ff : 8'h00);
         bod_rst_ff  <= bod_hit;
         wd_prev_ff  <= wd_s;
         wd_pulse_ff <= wd_s && !wd_prev_ff && wdog_enable_in;
      end
   end

   // Stretched internal reset
   always_ff @(posedge clk_in or negedge raw_rst_n) begin
      if (!raw_rst_n) begin
         int_rst_ff <= 1'b1;
         start_ff   <= 1'b0;
      end else begin
         int_rst_ff <= !cnt_done || src_hold;
         start_ff   <= int_rst_ff && cnt_done && !src_hold;
      end
   end

   // Bus decode
   wire req       = avs_read_in || avs_write_in;
   wire acc       = req && !wait_ff;
   wire hit_mcu   = (avs_address_in == MCU_CONTROL_OFS);
   wire hit_prr   = (avs_address_in == POWER_REDUCTION_OFS);
   wire hit_stat  = (avs_address_in == SYS_STATUS_OFS);
   wire wr_mcu    = acc && avs_write_in && hit_mcu;
   wire wr_prr    = acc && avs_write_in && hit_prr;
   wire [31:0] rd_mcu  = {24'h0, mcu_control_ff & ~MCU_RSVD_MASK};
   wire [31:0] rd_prr  = {24'h0, power_reduction_ff & ~PRR_RSVD_MASK};
   wire [31:0] rd_stat = {24'h0, bod_enabled, bandgap_ff, state_ff};
   wire [31:0] rd_mux  = hit_mcu ? rd_mcu :
                         hit_prr ? rd_prr :
                         hit_stat ? rd_stat : 32'h0;

   always_ff @(posedge clk_in or negedge raw_rst_n) begin
      if (!raw_rst_n) begin
         wait_ff  <= 1'b1;
         rdata_ff <= 32'h0;
      end else begin
         wait_ff  <= !(req && wait_ff && !int_rst_ff);
         rdata_ff <= (req && wait_ff) ? rd_mux : rdata_ff;
      end
   end

   // Software registers
   always_ff @(posedge clk_in or negedge raw_rst_n) begin
      if (!raw_rst_n) begin
         mcu_control_ff     <= MCU_CONTROL_RST;
         power_reduction_ff <= POWER_REDUCTION_RST;
      end else if (int_rst_ff) begin
         mcu_control_ff     <= MCU_CONTROL_RST;
         power_reduction_ff <= POWER_REDUCTION_RST;
      end else begin
         if (wr_mcu) begin
            mcu_control_ff <= avs_writedata_in[7:0] & ~MCU_RSVD_MASK;
         end
         if (wr_prr) begin
            power_reduction_ff <= avs_writedata_in[7:0] & ~PRR_RSVD_MASK;
         end
      end
   end

   // Sleep sequencing
   wire       sleep_en = mcu_control_ff[SLEEP_ENABLE_BIT];
   wire [1:0] sm_sel   = {mcu_control_ff[SLEEP_SEL_HI],
                          mcu_control_ff[SLEEP_SEL_LO]};
   wire       go_sleep = sleep_instr_in && sleep_en;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         RSP_ACTIVE: begin
            if (go_sleep) begin
               case (sm_sel)
                  SM_IDLE:  nxt_state = RSP_IDLE;
                  SM_ADCNR: nxt_state = RSP_ADCNR;
                  SM_PDOWN: nxt_state = RSP_PDOWN;
                  default:  nxt_state = RSP_STDBY;
               endcase
            end
         end
         RSP_IDLE, RSP_ADCNR, RSP_PDOWN: begin
            if (wake_event_in) begin
               nxt_state = RSP_ACTIVE;
            end
         end
         RSP_STDBY: begin
            if (wake_event_in) begin
               nxt_state = RSP_WAKE;
            end
         end
         RSP_WAKE: begin
            if (wake_cnt_ff == 3'(STBY_WAKE_CYC - 1)) begin
               nxt_state = RSP_ACTIVE;
            end
         end
         default: nxt_state = RSP_ACTIVE;
      endcase
   end

   wire nxt_cpu = (nxt_state == RSP_ACTIVE);
   wire nxt_io  = nxt_cpu || (nxt_state == RSP_IDLE);
   wire nxt_adc = nxt_io || (nxt_state == RSP_ADCNR);
   wire nxt_osc = !(nxt_state == RSP_PDOWN);
   wire [3:0] nxt_pclk = {nxt_io, nxt_io, nxt_io, nxt_adc} &
                         ~power_reduction_ff[3:0];
   wire nxt_bg  = bod_enabled || comparator_bandgap_select_in ||
                  adc_enable_in;

   // Reference follows its requesters through pin and power-on resets
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         bandgap_ff <= 1'b0;
      end else begin
         bandgap_ff <= nxt_bg;
      end
   end

   always_ff @(posedge clk_in or negedge raw_rst_n) begin
      if (!raw_rst_n) begin
         state_ff    <= RSP_ACTIVE;
         wake_cnt_ff <= 3'h0;
         cpu_en_ff   <= 1'b0;
         io_en_ff    <= 1'b0;
         adc_en_ff   <= 1'b0;
         osc_ff      <= 1'b1;
         pclk_ff     <= 4'h0;
         pacc_ff     <= 4'h0;
         adc_off_ff  <= 1'b0;
         mux_ok_ff   <= 1'b1;
      end else begin
         state_ff    <= int_rst_ff ? RSP_ACTIVE : nxt_state;
         wake_cnt_ff <= (state_ff == RSP_WAKE) ? wake_cnt_ff + 3'h1 : 3'h0;
         cpu_en_ff   <= nxt_cpu && !int_rst_ff;
         io_en_ff    <= nxt_io && !int_rst_ff;
         adc_en_ff   <= nxt_adc && !int_rst_ff;
         osc_ff      <= nxt_osc;
         pclk_ff     <= int_rst_ff ? 4'h0 : nxt_pclk;
         pacc_ff     <= ~power_reduction_ff[3:0];
         adc_off_ff  <= power_reduction_ff[GATE_ADC];
         mux_ok_ff   <= !power_reduction_ff[GATE_ADC];
      end
   end

   assign avs_readdata_out       = rdata_ff;
   assign avs_waitrequest_out    = wait_ff;
   assign sys_reset_out          = int_rst_ff;
   assign reset_vector_start_out = start_ff;
   assign clk_cpu_en_out         = cpu_en_ff;
   assign clk_io_en_out          = io_en_ff;
   assign clk_adc_en_out         = adc_en_ff;
   assign osc_en_out             = osc_ff;
   assign periph_clk_en_out      = pclk_ff;
   assign periph_access_en_out   = pacc_ff;
   assign adc_shutdown_out       = adc_off_ff;
   assign acmp_mux_en_out        = mux_ok_ff;
   assign bandgap_en_out         = bandgap_ff;

   AST_SLEEP_DECODE: assert property (@(posedge clk_in)
      disable iff (!resetn_in || int_rst_ff)
      (state_ff == RSP_ACTIVE && go_sleep && sm_sel == SM_PDOWN)
      |=> (state_ff == RSP_PDOWN) ##1 !osc_ff)
      else $error("power-down not entered");
   AST_SE_GATE: assert property (@(posedge clk_in)
      disable iff (!resetn_in || int_rst_ff)
      (state_ff == RSP_ACTIVE && !sleep_en) |=> state_ff == RSP_ACTIVE)
      else $error("sleep without enable");
   AST_MCU_RSVD: assert property (@(posedge clk_in)
      disable iff (!resetn_in)
      (!wait_ff && avs_read_in && hit_mcu) |-> !rdata_ff[MCU_RSVD_BIT])
      else $error("reserved control bit read one");
   AST_PRR_RSVD: assert property (@(posedge clk_in)
      disable iff (!resetn_in)
      (!wait_ff && avs_read_in && hit_prr) |-> rdata_ff[7:4] == 4'h0)
      else $error("reserved gate bits read nonzero");
   AST_T16_GATE: assert property (@(posedge clk_in)
      disable iff (!resetn_in)
      power_reduction_ff[GATE_TIMER16] |=> !pclk_ff[GATE_TIMER16])
      else $error("timer16 clock not stopped");
   AST_WDOG_PULSE: assert property (@(posedge clk_in)
      disable iff (!resetn_in)
      $rose(wd_pulse_ff) |=> !wd_pulse_ff ##1 int_rst_ff)
      else $error("watchdog pulse not one cycle");
   AST_BOD_FILTER: assert property (@(posedge clk_in)
      disable iff (!resetn_in)
      $rose(bod_rst_ff) |-> $past(bod_low_s, 2))
      else $error("brown-out acted on short dip");
   AST_BANDGAP: assert property (@(posedge clk_in)
      disable iff (!resetn_in)
      ##1 (bandgap_ff == $past(nxt_bg)))
      else $error("bandgap enable wrong");
   AST_STBY_WAKE: assert property (@(posedge clk_in)
      disable iff (!resetn_in || int_rst_ff)
      (state_ff == RSP_STDBY && wake_event_in) |=> ##6 state_ff == RSP_ACTIVE)
      else $error("standby wake not six cycles");
   AST_HOLD: assert property (@(posedge clk_in)
      disable iff (!resetn_in)
      src_hold |=> int_rst_ff [*2])
      else $error("reset released while source active");
endmodule : rsp_top

// [tb/rsp_core_model.sv]
`timescale 1ns/1ps
module rsp_core_model (
   input  wire logic       clk_in,
   input  wire logic       sys_reset_in,
   input  wire logic       vector_start_in,
   input  wire logic       sleep_req_in,
   output logic            sleep_instr_out,
   output logic [7:0]      boots_out
);
   initial begin
      sleep_instr_out = 1'b0;
      boots_out       = 8'h00;
   end
   // Sleep issued whenever requested, enable bit not checked, never in reset
   always @(posedge clk_in) begin
      sleep_instr_out <= sleep_req_in & ~sys_reset_in;
      if (vector_start_in) begin
         boots_out <= boots_out + 8'h01;
      end
   end
endmodule : rsp_core_model

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
   import rsp_pkg::*;
   localparam int TMID  = 20;
   localparam int TLONG = 40;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic        wait_r;
   logic        por = 1'b0;
   logic        pin_n = 1'b1;
   logic        pin_en = 1'b1;
   logic        wd = 1'b0;
   logic        wd_en = 1'b1;
   logic        bo = 1'b0;
   logic [2:0]  bo_f = BOD_FUSE_OFF;
   logic [1:0]  startup_time_fuses = 2'h0;
   logic [3:0]  cks = 4'h2; // Crystal clock kept while standby is used
   logic        cbg = 1'b0;
   logic        adc_en = 1'b0;
   logic        wake = 1'b0;
   logic        sleep_req = 1'b0;
   logic        sleep_instr, sys_rst, vec, cpu_en, io_en, aclk, osc_en;
   logic        adc_sd, acmp, bg;
   logic [3:0]  pclk, pacc, g;
   logic [7:0]  boots;
   logic [1:0]  m;
   logic [31:0] q;
   logic [3:0]  tbl [4] = '{4'h7, 4'h3, 4'h0, 4'h1};
   int          n_mismatch = 0;
   int          checked = 0;
   int          exp_boots = 0;
   int          i, n;

   always #(CLK_PERIOD_NS / 2) clk = ~clk;

   rsp_top #(.TOUT_MID(TMID), .TOUT_LONG(TLONG)) u_rsp_top (
      .clk_in(clk), .resetn_in(resetn), .avs_address_in(addr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wait_r),
      .poweron_low_in(por), .reset_pin_n_in(pin_n),
      .reset_pin_enable_in(pin_en), .wdog_expire_in(wd),
      .wdog_enable_in(wd_en), .brownout_low_in(bo),
      .brownout_level_fuses_in(bo_f), .startup_time_fuses_in(startup_time_fuses),
      .clock_select_fuses_in(cks), .comparator_bandgap_select_in(cbg),
      .adc_enable_in(adc_en), .sleep_instr_in(sleep_instr),
      .wake_event_in(wake), .sys_reset_out(sys_rst),
      .reset_vector_start_out(vec), .clk_cpu_en_out(cpu_en),
      .clk_io_en_out(io_en), .clk_adc_en_out(aclk), .osc_en_out(osc_en),
      .periph_clk_en_out(pclk), .periph_access_en_out(pacc),
      .adc_shutdown_out(adc_sd), .acmp_mux_en_out(acmp),
      .bandgap_en_out(bg));

   rsp_core_model u_rsp_core_model (
      .clk_in(clk), .sys_reset_in(sys_rst), .vector_start_in(vec),
      .sleep_req_in(sleep_req), .sleep_instr_out(sleep_instr),
      .boots_out(boots));

   task end_sim;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim

   task chk(input logic [31:0] got, input logic [31:0] exp,
            input string msg);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t %s: got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   task cyc(input int k);
      repeat (k) @(posedge clk);
   endtask : cyc

   task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      int k;
      k = 0;
      addr <= a;
      wr <= w;
      rd <= ~w;
      wdata <= {24'h0, d};
      @(posedge clk);
      while (wait_r !== 1'b0) begin
         k++;
         if (k > 50) begin
            n_mismatch++;
            $display("[FAIL] %0t bus answer missing", $time);
            end_sim();
         end
         @(posedge clk);
      end
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask : bus

   task rd_chk(input logic [3:0] a, input logic [7:0] e, input string s);
      bus(1'b0, a, 8'h00);
      chk(q, {24'h0, e}, s);
   endtask : rd_chk

   task wait_bit(input int which, input logic v, input int lim,
                 output int k);
      k = 0;
      while (k < lim && ((which == 0) ? sys_rst : cpu_en) !== v) begin
         @(posedge clk);
         k++;
      end
   endtask : wait_bit

   task recover(input int nexp, input string msg);
      int k;
      wait_bit(0, 1'b0, 300, k);
      chk(k >= nexp && k <= nexp + 6, 1'b1, msg);
      cyc(3);
      exp_boots++;
      chk(boots, exp_boots, "boot count");
   endtask : recover

   task do_sleep;
      sleep_req <= 1'b1;
      cyc(1);
      sleep_req <= 1'b0;
   endtask : do_sleep

   initial begin
      #(CLK_PERIOD_NS * 100000);
      n_mismatch++;
      $display("[FAIL] %0t run limit reached", $time);
      end_sim();
   end

   initial begin
      cyc(4);
      resetn <= 1'b1;
      recover(6, "power-up release");
      rd_chk(MCU_CONTROL_OFS, MCU_CONTROL_RST, "ctrl init");
      rd_chk(POWER_REDUCTION_OFS, POWER_REDUCTION_RST, "prr init");
      rd_chk(SYS_STATUS_OFS, {2'b00, RSP_ACTIVE}, "status init");
      bus(1'b1, MCU_CONTROL_OFS, 8'hff);
      rd_chk(MCU_CONTROL_OFS, ~MCU_RSVD_MASK, "ctrl reserved");
      bus(1'b1, POWER_REDUCTION_OFS, 8'hff);
      rd_chk(POWER_REDUCTION_OFS, ~PRR_RSVD_MASK, "prr reserved");
      bus(1'b1, 4'hc, 8'h5a);
      rd_chk(4'hc, 8'h00, "unmapped");
      $display("test registers done");
      for (i = 0; i < 4; i++) begin
         g = 4'h1 << i;
         bus(1'b1, POWER_REDUCTION_OFS, {4'h0, g});
         cyc(2);
         chk(pclk ^ g, 4'hf, "clock gate");
         chk(pacc ^ g, 4'hf, "access gate");
         chk({adc_sd, acmp}, (i == 0) ? 2'b10 : 2'b01, "adc off");
      end
      bus(1'b1, POWER_REDUCTION_OFS, 8'h00);
      cyc(2);
      chk(pclk, 4'hf, "clocks resume");
      $display("test gating done");
      for (i = 0; i < 4; i++) begin
         bo_f <= (i == 1) ? 3'h3 : BOD_FUSE_OFF;
         cbg <= (i == 2);
         adc_en <= (i == 3);
         cyc(3);
         chk(bg, i != 0, "bandgap");
      end
      bo_f <= BOD_FUSE_OFF;
      adc_en <= 1'b0;
      $display("test bandgap done");
      bus(1'b1, MCU_CONTROL_OFS, {3'b000, SM_PDOWN, 3'b000});
      do_sleep();
      cyc(3);
      chk(cpu_en, 1'b1, "sleep without enable");
      for (i = 0; i < 4; i++) begin
         m = i[1:0];
         bus(1'b1, MCU_CONTROL_OFS, {2'b00, 1'b1, m, 3'b000});
         do_sleep();
         cyc(3);
         chk({cpu_en, io_en, aclk, osc_en}, tbl[i], "sleep clocks");
         wake <= 1'b1;
         cyc(1);
         wake <= 1'b0;
         wait_bit(1, 1'b1, 30, n);
         chk((m == SM_STDBY) ? (n >= 7 && n <= 12) : (n <= 4), 1'b1,
             "wake delay");
      end
      $display("test sleep done");
      pin_n <= 1'b0;
      #1;
      chk({sys_rst, wait_r, osc_en, pacc}, 7'h70, "pin low");
      cyc(3);
      pin_n <= 1'b1;
      recover(6, "pin release");
      rd_chk(MCU_CONTROL_OFS, 8'h00, "ctrl after reset");
      pin_en <= 1'b0;
      pin_n <= 1'b0;
      wait_bit(0, 1'b1, 10, n);
      chk(n, 10, "pin disabled");
      pin_n <= 1'b1;
      pin_en <= 1'b1;
      startup_time_fuses <= 2'h1;
      por <= 1'b1;
      #1;
      chk(sys_rst, 1'b1, "power-on reset");
      cyc(3);
      por <= 1'b0;
      recover(TMID, "power-on release");
      startup_time_fuses <= 2'h2;
      wd <= 1'b1;
      cyc(1);
      wd <= 1'b0;
      wait_bit(0, 1'b1, 10, n);
      chk(n < 10, 1'b1, "watchdog reset");
      recover(TLONG, "watchdog release");
      wd_en <= 1'b0;
      wd <= 1'b1;
      cyc(1);
      wd <= 1'b0;
      wait_bit(0, 1'b1, 10, n);
      chk(n, 10, "watchdog disabled");
      $display("test pin power-on watchdog done");
      startup_time_fuses <= 2'h0;
      bo <= 1'b1;
      wait_bit(0, 1'b1, 80, n);
      chk(n, 80, "brown-out disabled");
      bo_f <= 3'h3;
      bo <= 1'b0;
      cyc(2);
      bo <= 1'b1;
      cyc(10);
      bo <= 1'b0;
      wait_bit(0, 1'b1, 80, n);
      chk(n, 80, "short dip");
      bo <= 1'b1;
      wait_bit(0, 1'b1, BOD_MIN_CYC + 10, n);
      chk(n >= BOD_MIN_CYC && n < BOD_MIN_CYC + 10, 1'b1,
          "dip");
      bo <= 1'b0;
      recover(6, "brown-out release");
      cks <= CLOCK_SELECT_FUSES_EXTCLK;
      startup_time_fuses <= 2'h2;
      pin_n <= 1'b0;
      cyc(3);
      pin_n <= 1'b1;
      recover(6, "external clock release");
      $display("test brown-out and fuses done");
      end_sim();
   end
endmodule : tb
